//--- hdl/epil_consts.svh
// Purpose: constants for the external pin interrupt latch
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes: definitions only
`ifndef EPIL_CONSTS_SVH
`define EPIL_CONSTS_SVH

`define EPIL_ADDR_W 4
`define EPIL_OFS_STATCTL 4'h0
`define EPIL_OFS_BRKCTL 4'h4
`define EPIL_OFS_VECTOR 4'h8
`define EPIL_BIT_MODE 0
`define EPIL_BIT_MASK 1
`define EPIL_BIT_ACK 2
`define EPIL_BIT_PEND 3
`define EPIL_BIT_PINLVL 4
`define EPIL_BIT_BREAK_CLEAR_ENABLE 0
`define EPIL_BIT_BRKST 1
`define EPIL_VEC_ADDR 16'hfffa
`define EPIL_HTRANS_NONSEQ 2'h2

`endif

//--- hdl/epil_pkg.sv
// Purpose: types for the external pin interrupt latch
// Assumes: nothing
// Notes: constants live in epil_consts.svh
package epil_pkg;
    typedef enum logic [1:0] {
        EPIL_ACC_NONE,
        EPIL_ACC_READ,
        EPIL_ACC_WRITE
    } epil_acc_e;
endpackage

//--- hdl/epil_pin_sync.sv
// Purpose: two-stage synchroniser with falling edge detect
// Assumes: pin is asynchronous to clk, idle high
// Notes: first stage read only by second stage; stages free-run through reset
`timescale 1ns/1ns
`default_nettype none
module epil_pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinAsync,
    output logic pinLevel,
    output logic pinFall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // the stages keep sampling during reset, so a pin held low through
    // reset leaves no false falling edge behind once reset is released
    always_ff @(posedge clk) begin
        meta_ff <= pinAsync;
    end

    always_ff @(posedge clk) begin
        sync_ff <= meta_ff;
    end

    always_ff @(posedge clk) begin
        prev_ff <= sync_ff;
    end

    assign pinLevel = sync_ff;
    assign pinFall = prev_ff & ~sync_ff;
endmodule
`default_nettype wire

//--- hdl/epil_irq_latch.sv
// Purpose: external active-low pin interrupt latch with AHB-Lite registers
// Assumes: one clock, synchronous active-low reset, word accesses only
// Notes: zero wait states; vector fetch acknowledge comes from the cpu core
`timescale 1ns/1ns
`default_nettype none
`include "epil_consts.svh"
module epil_irq_latch
    import epil_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hsel,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic irqPinN,
    input wire logic vectorFetchAck,
    input wire logic cpuIntMask,
    input wire logic breakState,
    output logic cpuIrqReq,
    output logic [15:0] irqVectorAddr,
    output logic branchPinHigh,
    output logic branchPinLow
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic pinLevel;
    logic pinFall;

    epil_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinAsync(irqPinN),
        .pinLevel(pinLevel),
        .pinFall(pinFall)
    );

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    epil_acc_e acc_ff;
    logic [`EPIL_ADDR_W-1:0] addr_ff;
    epil_acc_e nxt_acc;
    wire addrValid = hsel & hready & (htrans == `EPIL_HTRANS_NONSEQ);

    always_comb begin
        nxt_acc = EPIL_ACC_NONE;
        if (addrValid) begin
            nxt_acc = hwrite ? EPIL_ACC_WRITE : EPIL_ACC_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_ff <= EPIL_ACC_NONE;
            addr_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            addr_ff <= haddr[`EPIL_ADDR_W-1:0];
        end
    end

    wire wrPhase = (acc_ff == EPIL_ACC_WRITE);
    wire rdNext = (nxt_acc == EPIL_ACC_READ);
    wire wrStatCtl = wrPhase & (addr_ff == `EPIL_OFS_STATCTL);
    wire wrBrkCtl = wrPhase & (addr_ff == `EPIL_OFS_BRKCTL);

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic mode_ff;
    logic mask_ff;
    logic break_clear_enable_ff;
    logic latch_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_ff <= 1'b0;
            mask_ff <= 1'b0;
            break_clear_enable_ff <= 1'b0;
        end else begin
            if (wrStatCtl) begin
                mode_ff <= hwdata[`EPIL_BIT_MODE];
                mask_ff <= hwdata[`EPIL_BIT_MASK];
            end
            if (wrBrkCtl) begin
                break_clear_enable_ff <= hwdata[`EPIL_BIT_BREAK_CLEAR_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------
    // request latch
    // ------------------------------------------------------------
    wire ackWrite = wrStatCtl & hwdata[`EPIL_BIT_ACK];
    wire ackAllowed = ~breakState | break_clear_enable_ff;
    wire ackAny = (vectorFetchAck | ackWrite) & ackAllowed;
    wire levelHold = mode_ff & ~pinLevel;
    wire setReq = pinFall;
    wire nxt_latch = setReq | (latch_ff & ~ackAny);
    // level mode: an earlier acknowledge clears the latch, the low pin keeps
    // the request pending, so the request ends once both have happened
    wire pendNow = latch_ff | levelHold;
    wire pendNext = nxt_latch | levelHold;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_ff <= 1'b0;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // ------------------------------------------------------------
    // outputs toward the cpu
    // ------------------------------------------------------------
    wire nxt_req = pendNext & ~mask_ff & ~cpuIntMask;
    wire [31:0] statWord = {27'h0, pinLevel, pendNow, 1'b0, mask_ff, mode_ff};
    wire [31:0] brkWord = {30'h0, breakState, break_clear_enable_ff};
    wire [31:0] vecWord = {16'h0, `EPIL_VEC_ADDR};
    wire [`EPIL_ADDR_W-1:0] rdAddr = haddr[`EPIL_ADDR_W-1:0];
    wire [31:0] rdMux = (rdAddr == `EPIL_OFS_STATCTL) ? statWord :
                        (rdAddr == `EPIL_OFS_BRKCTL) ? brkWord :
                        (rdAddr == `EPIL_OFS_VECTOR) ? vecWord : 32'h0;

    wire [31:0] nxt_hrdata = rdNext ? rdMux : 32'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuIrqReq <= 1'b0;
        end else begin
            cpuIrqReq <= nxt_req;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqVectorAddr <= 16'h0;
        end else begin
            irqVectorAddr <= `EPIL_VEC_ADDR;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            branchPinHigh <= 1'b1;
        end else begin
            branchPinHigh <= pinLevel;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            branchPinLow <= 1'b0;
        end else begin
            branchPinLow <= ~pinLevel;
        end
    end

    // ------------------------------------------------------------
    // bus response
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0;
        end else begin
            hrdata <= nxt_hrdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- test/epil_monitor.sv
// Purpose: port checks for the pin interrupt latch
// Assumes: registered outputs
// Notes: bound after the module
`timescale 1ns/1ns
`default_nettype none
module epil_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irqPinN,
    input wire logic vectorFetchAck,
    input wire logic cpuIntMask,
    input wire logic breakState,
    input wire logic cpuIrqReq,
    input wire logic [15:0] irqVectorAddr,
    input wire logic branchPinHigh,
    input wire logic branchPinLow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_quiet_ack;
        irqPinN [*5] ##0 (vectorFetchAck && !breakState);
    endsequence
    a_ack_clears: assert property (s_quiet_ack |=> !cpuIrqReq) else $error("ack");
    a_vec_fixed: assert property ($past(rst_n) |-> irqVectorAddr == 16'hfffa) else $error("vec");
    a_pin_pair: assert property (branchPinHigh != branchPinLow) else $error("pair");
    a_pin_rise: assert property ($rose(irqPinN) |-> ##[1:4] branchPinHigh) else $error("rise");
    a_pin_fall: assert property ($fell(irqPinN) |-> ##[1:4] branchPinLow) else $error("fall");
    a_glob_mask: assert property ($past(cpuIntMask) |-> !cpuIrqReq) else $error("mask");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !cpuIrqReq)
        else $error("reset");
    a_pin_lag: assert property ($past(rst_n) && $past(rst_n, 4) |->
        branchPinHigh == $past(irqPinN, 2) || branchPinHigh == $past(irqPinN, 3)) else $error("lag");
endmodule
bind epil_irq_latch epil_monitor mon (.clk, .rst_n, .irqPinN, .vectorFetchAck, .cpuIntMask,
    .breakState, .cpuIrqReq, .irqVectorAddr, .branchPinHigh, .branchPinLow);
`default_nettype wire

//--- test/epil_pin_drv.sv
// Purpose: external circuit on the interrupt pin
// Assumes: pin pulled up when released
// Notes: pullLow asks for a low drive
`timescale 1ns/1ns
`default_nettype none
module epil_pin_drv (
    input wire logic clk,
    input wire logic pullLow,
    output logic irqPinN
);
    // released pin rests at the pull-up level, changes off the bench edge
    initial irqPinN = 1'b1;
    always @(posedge clk) irqPinN <= #3 ~pullLow;
endmodule
`default_nettype wire

//--- test/external_pin_interrupt_latch_tb.sv
// Purpose: bench for the pin interrupt latch
// Assumes: zero wait bus slave
// Notes: pin driven through epil_pin_drv
`timescale 1ns/1ns
`default_nettype none
module external_pin_interrupt_latch_tb;
    logic clk = 1'b0, rst_n = 1'b0, hw = 1'b0, ack = 1'b0, im = 1'b0, brk = 1'b0, low = 1'b0;
    logic ro, hs, req, bh, bl, pin;
    logic [1:0] ht = 2'h0;
    logic [15:0] va;
    logic [31:0] ha = 32'h0, wd = 32'h0, hr;
    int errors = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    epil_pin_drv drv (.clk, .pullLow(low), .irqPinN(pin));
    epil_irq_latch dut (.clk, .rst_n, .haddr(ha), .htrans(ht), .hwrite(hw), .hsize(3'h2),
        .hwdata(wd), .hsel(1'b1), .hready(ro), .hrdata(hr), .hreadyout(ro), .hresp(hs),
        .irqPinN(pin), .vectorFetchAck(ack), .cpuIntMask(im), .breakState(brk),
        .cpuIrqReq(req), .irqVectorAddr(va), .branchPinHigh(bh), .branchPinLow(bl));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        n_compared++;
        if (a !== e) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge clk);
        ht <= 2'h2;
        ha <= a;
        hw <= w;
        do @(posedge clk); while (ro !== 1'b1);
        ht <= 2'h0;
        wd <= d;
        do @(posedge clk); while (ro !== 1'b1);
        r = hr;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [31:0] a, e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
        chk({hs, ro}, 32'h1);
    endtask
    task automatic pulse;
        low <= 1'b1;
        cyc(6);
        low <= 1'b0;
        cyc(6);
    endtask
    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_edge;
        low <= 1'b1;
        cyc(6);
        chk(req, 1'b1);
        chk(bl, 1'b1);
        low <= 1'b0;
        cyc(6);
        im <= 1'b1;
        cyc(2);
        chk(req, 1'b0);
        im <= 1'b0;
        ack <= 1'b1;
        cyc(1);
        ack <= 1'b0;
        cyc(2);
        chk(req, 1'b0);
        rdc(32'h0, 32'h10);
        $display("edge done");
    endtask
    task automatic t_mask;
        wr(32'h0, 32'h2);
        pulse();
        chk(req, 1'b0);
        rdc(32'h0, 32'h1a);
        wr(32'h0, 32'h6);
        rdc(32'h0, 32'h12);
        pulse();
        rdc(32'h0, 32'h1a);
        wr(32'h0, 32'h4);
        $display("mask done");
    endtask
    task automatic t_level;
        logic [31:0] x;
        wr(32'h0, 32'h1);
        low <= 1'b1;
        cyc(6);
        wr(32'h0, 32'h7);
        rdc(32'h0, 32'h0b);
        chk(req, 1'b0);
        low <= 1'b0;
        cyc(6);
        rdc(32'h0, 32'h13);
        wr(32'h0, 32'h1);
        low <= 1'b1;
        cyc(6);
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        bus(1'b0, 32'h0, 32'h0, x);
        chk(x, 32'h0);
        low <= 1'b0;
        cyc(6);
        wr(32'h0, 32'h4);
        $display("level done");
    endtask
    task automatic t_brk;
        brk <= 1'b1;
        pulse();
        wr(32'h0, 32'h4);
        rdc(32'h0, 32'h18);
        wr(32'h4, 32'h1);
        wr(32'h0, 32'h4);
        rdc(32'h4, 32'h3);
        brk <= 1'b0;
        rdc(32'h0, 32'h10);
        wr(32'h4, 32'h0);
        $display("break done");
    endtask
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(3);
        rdc(32'h0, 32'h10);
        rdc(32'h4, 32'h0);
        rdc(32'h8, 32'hfffa);
        rdc(32'hc, 32'h0);
        $display("reset done");
        t_edge();
        t_mask();
        t_level();
        t_brk();
        close_out();
    end
    initial begin
        #100000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
